// >>> verilog/ocb_pkg.sv
// Package with addresses, field layout, reset values and carrier types of the output configuration bank.
package ocb_pkg;

    // The subsystem ID is fixed for this bank; the value is an arbitrary choice.
    localparam logic [2:0] SUB_ID       = 3'h0;

    localparam logic [3:0] ADDR_CONFIG  = 4'h3;
    localparam logic [3:0] ADDR_CALBIAS = 4'h4;
    localparam logic [3:0] ADDR_COARSE  = 4'h5;
    localparam logic [3:0] ADDR_UPPER   = 4'h6;
    localparam logic [3:0] ADDR_GAIN    = 4'h7;

    localparam int NUM_REGS   = 5;
    localparam int REG_W      = 9;
    localparam int IDX_CONFIG = 0;
    localparam int IDX_CALB   = 1;
    localparam int IDX_GAIN   = 4;

    localparam int PRIO_LSB   = 0;
    localparam int POS_EN_BIT = 2;
    localparam int NEG_EN_BIT = 3;
    localparam int TERM_BIT   = 4;
    localparam int RES_BIT    = 5;
    localparam int MUTE_LSB   = 7;
    localparam int GAIN_LSB   = 0;

    localparam logic [1:0] PRIO_LOW  = 2'h1;
    localparam logic [1:0] PRIO_BEST = 2'h3;
    localparam logic [3:0] GAIN_MAX  = 4'ha;
    localparam logic [5:0] DIV_MAX   = 6'h3e;

    localparam logic [8:0] RST_CONFIG  = 9'h092;
    localparam logic [8:0] RST_CALBIAS = 9'h0c9;
    localparam logic [8:0] RST_COARSE  = 9'h0aa;
    localparam logic [8:0] RST_UPPER   = 9'h0ff;
    localparam logic [8:0] RST_GAIN    = 9'h0f1;

    localparam logic       RST_MUTED   = 1'h1;
    localparam logic [5:0] RST_RATIO   = 6'h01;

    typedef enum logic [1:0] {
        ocb_mute_div_zero,
        ocb_mute_cal,
        ocb_mute_cal_unlock,
        ocb_mute_always
    } ocb_mute_e;

    // One main-register write: data in the upper nine bits, then address, then subsystem ID.
    typedef struct packed {
        logic [8:0] data;
        logic [3:0] addr;
        logic [2:0] id;
    } ocb_wr_s;

    typedef struct packed {
        logic [1:0] prio;
        logic       low_current;
        logic       best_noise;
        logic       pos_en;
        logic       neg_en;
        logic       int_term;
        logic       raise_res;
        ocb_mute_e  mute_mode;
        logic [3:0] gain;
        logic       gain_valid;
    } ocb_cfg_s;

    localparam ocb_cfg_s CFG_RST = '{
        prio:        2'h2,
        low_current: 1'h0,
        best_noise:  1'h0,
        pos_en:      1'h0,
        neg_en:      1'h0,
        int_term:    1'h1,
        raise_res:   1'h0,
        mute_mode:   ocb_mute_cal,
        gain:        4'h1,
        gain_valid:  1'h1
    };

endpackage : ocb_pkg

// >>> verilog/ocb_mute.sv
// Mute decision and output divide ratio decode of the output configuration bank.
`timescale 1ns/1ps

module ocb_mute (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire ocb_pkg::ocb_mute_e mute_mode,
    input  wire logic [5:0]        divide_ratio,
    input  wire logic              cal_active,
    input  wire logic              lock_gpo,
    output logic                   muted,
    output logic [5:0]             eff_ratio
);

    typedef struct packed {
        logic       muted;
        logic [5:0] eff_ratio;
    } ocb_mute_state_s;

    ocb_mute_state_s st_r;
    ocb_mute_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        // Odd ratios above one fall back to the even ratio below; beyond the top the top ratio holds.
        if (divide_ratio <= 6'h01) begin
            st_nxt.eff_ratio = divide_ratio; // [R13]
        end else if (divide_ratio > ocb_pkg::DIV_MAX) begin
            st_nxt.eff_ratio = ocb_pkg::DIV_MAX; // [R13]
        end else begin
            st_nxt.eff_ratio = {divide_ratio[5:1], 1'h0}; // [R13]
        end
        case (mute_mode) // [R6] [R8]
            ocb_pkg::ocb_mute_div_zero:   st_nxt.muted = (divide_ratio == 6'h00);
            ocb_pkg::ocb_mute_cal:        st_nxt.muted = cal_active;
            ocb_pkg::ocb_mute_cal_unlock: st_nxt.muted = cal_active || !lock_gpo; // [R7]
            default:                      st_nxt.muted = 1'h1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r.muted     <= ocb_pkg::RST_MUTED;
            st_r.eff_ratio <= ocb_pkg::RST_RATIO;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign muted     = st_r.muted;
    assign eff_ratio = st_r.eff_ratio;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    combo_mute_a: assert property ((mute_mode == ocb_pkg::ocb_mute_cal_unlock) && (cal_active || !lock_gpo) // [R7]
        |=> muted) else $error("combined mode failed to mute");
    combo_clear_a: assert property ((mute_mode == ocb_pkg::ocb_mute_cal_unlock) && !cal_active && lock_gpo // [R7]
        |=> !muted) else $error("combined mode muted while locked and idle");
    always_mute_a: assert property ((mute_mode == ocb_pkg::ocb_mute_always) [*2] |-> muted) // [R6]
        else $error("always mode not muted");
    div_zero_a: assert property ((mute_mode == ocb_pkg::ocb_mute_div_zero) |=> (muted == ($past(divide_ratio) == 6'h00))) // [R8]
        else $error("divide-zero mode mute wrong");
    ratio_even_a: assert property ($past(divide_ratio) > 6'h01 |-> (eff_ratio[0] == 1'h0) && (eff_ratio >= 6'h02)) // [R13]
        else $error("effective ratio not even");

endmodule : ocb_mute

// >>> verilog/ocb_bank.sv
// Top of the write-only output configuration bank: indirect write decode, five registers and decoded controls.
`timescale 1ns/1ps

// Function
// R1 - Priority code 01 low current, 11 best noise
// R2 - Bit 2 enables positive output pin
// R3 - Bit 3 enables negative output pin
// R4 - Bit 4 enables internal termination, resets one
// R5 - Bit 5 raises output termination resistance
// R6 - Mute mode field selects muting condition
// R7 - Combined mode mutes on calibration or unlock
// R8 - Mute codes map in order, reset 01
// R9 - Gain code resets 0001, valid through 1010
// R10 - Host writes reserved fields with defaults
// R11 - Host keeps calibration bias register default
// R12 - Write word carries ID, address, data
// R13 - Divide ratio zero mutes, one undivided
module ocb_bank (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             wr_stb,
    input  wire ocb_pkg::ocb_wr_s wr_word,
    input  wire logic [5:0]       divide_ratio,
    input  wire logic             cal_active,
    input  wire logic             lock_gpo,
    output ocb_pkg::ocb_cfg_s     cfg,
    output logic                  calbias_ok,
    output logic                  muted,
    output logic [5:0]            eff_ratio
);

    typedef struct packed {
        logic [ocb_pkg::NUM_REGS-1:0][ocb_pkg::REG_W-1:0] regs;
        ocb_pkg::ocb_cfg_s                                cfg;
        logic                                             calbias_ok;
    } ocb_bank_state_s;

    ocb_bank_state_s st_r;
    ocb_bank_state_s st_nxt;
    logic            wr_hit;
    logic [3:0]      wr_off;
    logic [8:0]      cfg_reg;
    logic [8:0]      gain_reg;

    // Only this subsystem and the addresses of this bank are taken; anything else belongs to another bank.
    assign wr_hit = wr_stb && (wr_word.id == ocb_pkg::SUB_ID) && (wr_word.addr >= ocb_pkg::ADDR_CONFIG)
                    && (wr_word.addr <= ocb_pkg::ADDR_GAIN); // [R12]
    assign wr_off = wr_word.addr - ocb_pkg::ADDR_CONFIG;

    always_comb begin
        st_nxt = st_r;
        if (wr_hit) begin
            st_nxt.regs[wr_off[2:0]] = wr_word.data; // [R12]
        end
        cfg_reg  = st_nxt.regs[ocb_pkg::IDX_CONFIG];
        gain_reg = st_nxt.regs[ocb_pkg::IDX_GAIN];
        st_nxt.cfg.prio        = cfg_reg[ocb_pkg::PRIO_LSB +: 2];
        st_nxt.cfg.low_current = (cfg_reg[ocb_pkg::PRIO_LSB +: 2] == ocb_pkg::PRIO_LOW); // [R1]
        st_nxt.cfg.best_noise  = (cfg_reg[ocb_pkg::PRIO_LSB +: 2] == ocb_pkg::PRIO_BEST); // [R1]
        st_nxt.cfg.pos_en      = cfg_reg[ocb_pkg::POS_EN_BIT]; // [R2]
        st_nxt.cfg.neg_en      = cfg_reg[ocb_pkg::NEG_EN_BIT]; // [R3]
        st_nxt.cfg.int_term    = cfg_reg[ocb_pkg::TERM_BIT]; // [R4]
        st_nxt.cfg.raise_res   = cfg_reg[ocb_pkg::RES_BIT]; // [R5]
        st_nxt.cfg.mute_mode   = ocb_pkg::ocb_mute_e'(cfg_reg[ocb_pkg::MUTE_LSB +: 2]); // [R6] [R8]
        st_nxt.cfg.gain        = gain_reg[ocb_pkg::GAIN_LSB +: 4]; // [R9]
        // Codes past the top swing step are still stored, but flagged so the output stage can ignore them.
        st_nxt.cfg.gain_valid  = (gain_reg[ocb_pkg::GAIN_LSB +: 4] <= ocb_pkg::GAIN_MAX); // [R9]
        // Other calibration bias settings are not supported, so this flag tells software it has left them.
        st_nxt.calbias_ok      = (st_nxt.regs[ocb_pkg::IDX_CALB] == ocb_pkg::RST_CALBIAS); // [R11]
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r.regs       <= {ocb_pkg::RST_GAIN, ocb_pkg::RST_UPPER, ocb_pkg::RST_COARSE,
                                ocb_pkg::RST_CALBIAS, ocb_pkg::RST_CONFIG}; // [R4] [R8] [R9] [R10]
            st_r.cfg        <= ocb_pkg::CFG_RST;
            st_r.calbias_ok <= 1'h1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg        = st_r.cfg;
    assign calbias_ok = st_r.calbias_ok;

    ocb_mute u_mute (
        .clk_sys      (clk_sys),
        .nrst         (nrst),
        .mute_mode    (st_r.cfg.mute_mode),
        .divide_ratio (divide_ratio),
        .cal_active   (cal_active),
        .lock_gpo     (lock_gpo),
        .muted        (muted),
        .eff_ratio    (eff_ratio)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence wr_config_s;
        wr_stb && (wr_word.id == ocb_pkg::SUB_ID) && (wr_word.addr == ocb_pkg::ADDR_CONFIG);
    endsequence

    sequence wr_gain_s;
        wr_stb && (wr_word.id == ocb_pkg::SUB_ID) && (wr_word.addr == ocb_pkg::ADDR_GAIN);
    endsequence

    pin_enables_a: assert property (wr_config_s |=> (cfg.pos_en == $past(wr_word.data[2]))
        && (cfg.neg_en == $past(wr_word.data[3]))) // [R2] [R3]
        else $error("output pin enables not taken from write");
    term_res_a: assert property (wr_config_s |=> (cfg.int_term == $past(wr_word.data[4]))
        && (cfg.raise_res == $past(wr_word.data[5]))) // [R4] [R5]
        else $error("termination controls not taken from write");
    prio_decode_a: assert property (wr_config_s |=> (cfg.low_current == ($past(wr_word.data[1:0]) == 2'h1))
        && (cfg.best_noise == ($past(wr_word.data[1:0]) == 2'h3))) // [R1]
        else $error("priority decode wrong");
    mute_field_a: assert property (wr_config_s |=> (cfg.mute_mode == ocb_pkg::ocb_mute_e'($past(wr_word.data[8:7])))) // [R6]
        else $error("mute mode not taken from write");
    gain_valid_a: assert property (wr_gain_s |=> (cfg.gain == $past(wr_word.data[3:0]))
        && (cfg.gain_valid == ($past(wr_word.data[3:0]) <= 4'ha))) // [R9]
        else $error("gain code or validity wrong");
    foreign_id_a: assert property (wr_stb && (wr_word.id != ocb_pkg::SUB_ID) |=> $stable(cfg) && $stable(calbias_ok)) // [R12]
        else $error("write with foreign ID changed bank");
    reset_value_a: assert property ($rose(nrst) && !wr_stb |=> !cfg.pos_en && !cfg.neg_en && cfg.int_term
        && (cfg.gain == 4'h1) && (cfg.mute_mode == ocb_pkg::ocb_mute_cal)) // [R4] [R8] [R9]
        else $error("reset values wrong");
    calbias_flag_a: assert property (wr_stb && (wr_word.id == ocb_pkg::SUB_ID) && (wr_word.addr == ocb_pkg::ADDR_CALBIAS)
        |=> (calbias_ok == ($past(wr_word.data) == 9'h0c9))) // [R11]
        else $error("calibration bias flag wrong");

endmodule : ocb_bank

// >>> sim/ocb_host.sv
// Host controller model that programs the bank through single main-register writes.
`timescale 1ns/1ps

module ocb_host (
    input  wire logic        clk_sys,
    output logic             wr_stb,
    output ocb_pkg::ocb_wr_s wr_word
);
    initial begin
        wr_stb  = 1'h0;
        wr_word = '0;
    end

    // The word is inverted once released so that nothing relies on a stale value.
    task automatic put(input logic [2:0] id, input logic [3:0] addr, input logic [8:0] data);
        @(posedge clk_sys);
        wr_stb  <= 1'h1;
        wr_word <= '{data: data, addr: addr, id: id};
        @(posedge clk_sys);
        wr_stb  <= 1'h0;
        wr_word <= ~wr_word;
    endtask : put

    task automatic put_cfg(input logic [1:0] mute, input logic [3:0] bits, input logic [1:0] prio);
        put(ocb_pkg::SUB_ID, ocb_pkg::ADDR_CONFIG, {mute, 1'h0, bits, prio});
    endtask : put_cfg

    task automatic put_gain(input logic [3:0] g);
        put(ocb_pkg::SUB_ID, ocb_pkg::ADDR_GAIN, {ocb_pkg::RST_GAIN[8:4], g});
    endtask : put_gain

    task automatic keep_calbias();
        put(ocb_pkg::SUB_ID, ocb_pkg::ADDR_CALBIAS, ocb_pkg::RST_CALBIAS);
    endtask : keep_calbias
endmodule : ocb_host

// >>> sim/ocb_bank_tb_top.sv
// Self-checking testbench of the output configuration bank.
`timescale 1ns/1ps

module ocb_bank_tb_top;
    logic              clk_sys;
    logic              nrst;
    logic [5:0]        divide_ratio;
    logic              cal_active;
    logic              lock_gpo;
    logic              wr_stb;
    ocb_pkg::ocb_wr_s  wr_word;
    ocb_pkg::ocb_cfg_s cfg;
    logic              calbias_ok;
    logic              muted;
    logic [5:0]        eff_ratio;
    int                miscompares = 0;
    int                checks_done = 0;
    int                cycles      = 0;

    initial clk_sys = 1'h0;
    always #25 clk_sys = ~clk_sys;

    ocb_host u_host (.clk_sys(clk_sys), .wr_stb(wr_stb), .wr_word(wr_word));

    ocb_bank dut (.clk_sys(clk_sys), .nrst(nrst), .wr_stb(wr_stb), .wr_word(wr_word),
        .divide_ratio(divide_ratio), .cal_active(cal_active), .lock_gpo(lock_gpo),
        .cfg(cfg), .calbias_ok(calbias_ok), .muted(muted), .eff_ratio(eff_ratio));

    task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic set_in(input logic [5:0] r, input logic c, input logic l);
        @(posedge clk_sys);
        divide_ratio <= r;
        cal_active   <= c;
        lock_gpo     <= l;
    endtask : set_in

    task automatic t_reset();
        chk(cfg, ocb_pkg::CFG_RST);
        chk({calbias_ok, muted, eff_ratio}, {1'h1, 1'h1, 6'h01});
    endtask : t_reset

    task automatic t_prio();
        logic [1:0] p;
        for (int i = 0; i < 4; i++) begin
            p = i[1:0];
            u_host.put_cfg(2'h1, 4'h0, p);
            settle(2);
            chk({cfg.prio, cfg.low_current, cfg.best_noise}, {p, p == 2'h1, p == 2'h3});
        end
    endtask : t_prio

    // A walking one also passes through the termination bit, so each of the four controls is seen alone.
    task automatic t_bits();
        logic [3:0] b;
        for (int i = 0; i < 4; i++) begin
            b = 4'h1 << i;
            u_host.put_cfg(2'h1, b, ocb_pkg::PRIO_LOW);
            settle(2);
            chk({cfg.pos_en, cfg.neg_en, cfg.int_term, cfg.raise_res}, {b[0], b[1], b[2], b[3]});
        end
    endtask : t_bits

    task automatic t_mute();
        logic [2:0] k;
        logic       e;
        for (int m = 0; m < 4; m++) begin
            u_host.put_cfg(m[1:0], 4'h0, ocb_pkg::PRIO_LOW);
            settle(2);
            chk(cfg.mute_mode, m[1:0]);
            for (int j = 0; j < 8; j++) begin
                k = j[2:0];
                set_in(k[0] ? 6'h00 : 6'h02, k[1], k[2]);
                settle(2);
                e = (m == 0) ? k[0] : (m == 1) ? k[1] : (m == 2) ? (k[1] | ~k[2]) : 1'h1;
                chk(muted, e);
            end
        end
    endtask : t_mute

    task automatic t_ratio();
        logic [5:0] tbl [6] = '{6'h00, 6'h01, 6'h03, 6'h3f, 6'h3e, 6'h02};
        logic [5:0] e;
        for (int i = 0; i < 6; i++) begin
            set_in(tbl[i], 1'h0, 1'h1);
            settle(2);
            e = (tbl[i] > 6'h3e) ? 6'h3e : (tbl[i] > 6'h01 && tbl[i][0]) ? tbl[i] - 6'h01 : tbl[i];
            chk(eff_ratio, e);
        end
    endtask : t_ratio

    task automatic t_gain();
        logic [3:0] tbl [4] = '{4'h0, 4'ha, 4'hb, 4'hf};
        for (int i = 0; i < 4; i++) begin
            u_host.put_gain(tbl[i]);
            settle(2);
            chk({cfg.gain, cfg.gain_valid}, {tbl[i], tbl[i] <= 4'ha});
        end
    endtask : t_gain

    // Foreign IDs and addresses beside the bank must leave priority, pin enables and mute mode untouched.
    task automatic t_refuse();
        u_host.put_cfg(2'h1, 4'h0, ocb_pkg::PRIO_BEST);
        u_host.put(3'h1, ocb_pkg::ADDR_CONFIG, 9'h1ff);
        u_host.put(ocb_pkg::SUB_ID, 4'h2, 9'h1ff);
        u_host.put(ocb_pkg::SUB_ID, 4'h8, 9'h1ff);
        settle(2);
        chk({cfg.prio, cfg.pos_en, cfg.neg_en, cfg.mute_mode}, {2'h3, 2'h0, 2'h1});
        u_host.put(ocb_pkg::SUB_ID, ocb_pkg::ADDR_CALBIAS, 9'h0c8);
        settle(2);
        chk(calbias_ok, 1'h0);
        u_host.keep_calbias();
        settle(2);
        chk(calbias_ok, 1'h1);
    endtask : t_refuse

    task automatic wrap_up();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        nrst         = 1'h0;
        divide_ratio = 6'h01;
        cal_active   = 1'h0;
        lock_gpo     = 1'h1;
        repeat (3) @(posedge clk_sys);
        #1;
        t_reset();
        @(posedge clk_sys);
        nrst <= 1'h1;
        t_prio();
        t_bits();
        t_mute();
        t_ratio();
        t_gain();
        t_refuse();
        wrap_up();
    end
endmodule : ocb_bank_tb_top
